/* File: ese_pkg.sv */
/*
 Constants, opcode patterns and types for the extended stack instruction
 executer. Assumes a core with 12-bit data addresses and a 21-bit program
 counter, four clock phases per instruction cycle.
*/
package ese_pkg;

   // Data path widths
   localparam int ADDR_W = 12;
   localparam int PC_W = 21;
   localparam int PTR_COUNT = 3;

   // Instruction phases, one clock each
   localparam logic [1:0] PH_Q1 = 2'h0;
   localparam logic [1:0] PH_Q2 = 2'h1;
   localparam logic [1:0] PH_Q3 = 2'h2;
   localparam logic [1:0] PH_Q4 = 2'h3;
   localparam logic [1:0] PH_RESET = 2'h0;

   // Opcode patterns
   localparam logic [7:0] OP_ADD_PTR = 8'he8;
   localparam logic [7:0] OP_PUSH_LIT = 8'hea;
   localparam logic [7:0] OP_MOVE = 8'heb;
   localparam logic [15:0] OP_CALL_WORKING_REGISTER = 16'h0014;
   localparam logic [1:0] SEL_RETURN_FORM = 2'h3;

   // Field positions
   localparam int LIT6_LSB = 0;
   localparam int SEL_LSB = 6;
   localparam int MOVE_KIND_BIT = 7;

   // Return address step for a one-word call
   localparam logic [PC_W-1:0] PC_STEP = 21'h000002;

   // Indirect addressing register window; defaults are arbitrary
   localparam logic [ADDR_W-1:0] INDIRECT_LO = 12'hfe0;
   localparam logic [ADDR_W-1:0] INDIRECT_HI = 12'hfef;

   // Values after reset
   localparam logic [ADDR_W-1:0] PTR_RESET = 12'h000;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
   localparam logic [ADDR_W-1:0] ADDR_RESET = 12'h000;

   // Constants of pointer arithmetic
   localparam logic [ADDR_W-1:0] PTR_DECREMENT = 12'h001;
   localparam logic [5:0] LIT6_PAD = 6'h00;
   localparam logic [4:0] LIT7_PAD = 5'h00;

   typedef enum logic [2:0] {
      ESE_OP_NONE,
      ESE_OP_ADD_PTR,
      ESE_OP_ADD_RET,
      ESE_OP_CALL_W,
      ESE_OP_MOVE_ABS,
      ESE_OP_MOVE_IDX,
      ESE_OP_PUSH_LIT
   } ese_op_type;

   typedef enum logic [1:0] {
      ESE_ST_FIRST,
      ESE_ST_SECOND_NOP,
      ESE_ST_SECOND_MOVE
   } ese_state_type;

endpackage

/* File: ese_qphase.sv */
/*
 Four-phase instruction cycle counter. Assumes a synchronous active-high
 reset on the core clock; phase Q1 is the first clock after release.
*/
`timescale 1ns/10ps
module ese_qphase
   import ese_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_rst,
   output logic [1:0] o_phase
);

   logic [1:0] phase;
   logic [1:0] next_phase;

   assign next_phase = phase + 2'h1;
   assign o_phase = phase;

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         phase <= PH_RESET;
      end else begin
         phase <= next_phase;
      end
   end

endmodule // ese_qphase

/* File: ese_exec.sv */
/*
 Decode and execution of the extended stack instructions of the core:
 add literal to pointer, add and return, call via working register, the
 two indexed moves and push literal. It holds the three file select
 pointers. Assumes the fetch path presents each instruction word (and the
 second word of a two-word move) for a whole instruction cycle, starting at
 phase Q1, and that the core carries out the strobes in the clock they show.
*/
// Behaviour
// RQ1: Extended opcodes are recognised only while the extended set enable is high.
// RQ2: Add literal to pointer adds the 6-bit literal to pointer 0, 1 or 2 in one cycle.
// RQ3: With select field 11 the literal goes to pointer 2 and the counter loads from the stack top.
// RQ4: Add and return takes two cycles, the second one a no-operation.
// RQ5: Call via working register first pushes the counter plus two onto the return stack.
// RQ6: The call then loads the counter from working register and the two latch bytes.
// RQ7: The call takes two cycles, the second a no-operation while the target is fetched.
// RQ8: The call leaves working, status and bank select registers untouched.
// RQ9: Indexed-to-absolute move reads pointer 2 plus offset and writes the 12-bit address.
// RQ10: Move addresses reach the whole 4096-byte data space.
// RQ11: Software never names the counter low byte or return stack top bytes as move target.
// RQ12: A move source on an indirect register reads as zero.
// RQ13: An indexed-to-indexed move to an indirect register writes nothing.
// RQ14: Indexed-to-indexed move takes two words and cycles, both addresses pointer 2 plus offset.
// RQ15: Indexed-to-absolute move reads in the first cycle and writes in Q4 of the second.
// RQ16: Push literal writes the literal at pointer 2 and then decrements pointer 2 in one cycle.
// RQ17: Pointer arithmetic wraps within 12 bits.
`timescale 1ns/10ps
module ese_exec
   import ese_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_extended_set_enable,
   input wire logic [15:0] i_instr_word,
   input wire logic i_instr_valid,
   input wire logic [PC_W-1:0] i_pc,
   input wire logic [PC_W-1:0] i_return_stack_top,
   input wire logic [7:0] i_working_register,
   input wire logic [7:0] i_counter_latch_high,
   input wire logic [7:0] i_counter_latch_upper,
   input wire logic [7:0] i_mem_rdata,
   input wire logic i_ptr_wr_en,
   input wire logic [1:0] i_ptr_wr_sel,
   input wire logic [ADDR_W-1:0] i_ptr_wr_data,
   output logic [1:0] o_phase,
   output logic o_claim,
   output logic o_owns_cycle,
   output logic [ADDR_W-1:0] o_pointer0,
   output logic [ADDR_W-1:0] o_pointer1,
   output logic [ADDR_W-1:0] o_pointer2,
   output logic o_stack_push,
   output logic [PC_W-1:0] o_stack_push_data,
   output logic o_stack_pop,
   output logic o_pc_load,
   output logic [PC_W-1:0] o_pc_load_value,
   output logic o_mem_rd,
   output logic o_mem_wr,
   output logic [ADDR_W-1:0] o_mem_addr,
   output logic [7:0] o_mem_wdata
);

   logic [1:0] phase;
   ese_state_type state;
   ese_state_type next_state;
   ese_op_type op;
   ese_op_type dec_op;
   logic [15:0] ir;
   logic [15:0] ir2;
   logic [ADDR_W-1:0] ptr [0:PTR_COUNT-1];
   logic [ADDR_W-1:0] src_addr;
   logic [ADDR_W-1:0] dst_addr;
   logic [7:0] move_data;

   ese_qphase u_qphase (
      .i_core_clk(i_core_clk),
      .i_rst(i_rst),
      .o_phase(phase)
   );

   // Decode of the word on the fetch path
   wire [7:0] w_hi = i_instr_word[15:8];
   wire [1:0] w_sel = i_instr_word[SEL_LSB+1:SEL_LSB];
   wire dec_add = (w_hi == OP_ADD_PTR) && (w_sel != SEL_RETURN_FORM);
   wire dec_addret = (w_hi == OP_ADD_PTR) && (w_sel == SEL_RETURN_FORM);
   wire dec_call = (i_instr_word == OP_CALL_WORKING_REGISTER);
   wire dec_mvabs = (w_hi == OP_MOVE) && !i_instr_word[MOVE_KIND_BIT];
   wire dec_mvidx = (w_hi == OP_MOVE) && i_instr_word[MOVE_KIND_BIT];
   wire dec_push = (w_hi == OP_PUSH_LIT);
   wire dec_any_raw = dec_add || dec_addret || dec_call ||
                      dec_mvabs || dec_mvidx || dec_push;
   wire dec_any = i_extended_set_enable && dec_any_raw; // [RQ1]

   always_comb begin
      dec_op = ESE_OP_NONE;
      if (dec_any) begin // [RQ1]
         if (dec_add) begin
            dec_op = ESE_OP_ADD_PTR;
         end else if (dec_addret) begin
            dec_op = ESE_OP_ADD_RET;
         end else if (dec_call) begin
            dec_op = ESE_OP_CALL_W;
         end else if (dec_mvabs) begin
            dec_op = ESE_OP_MOVE_ABS;
         end else if (dec_mvidx) begin
            dec_op = ESE_OP_MOVE_IDX;
         end else begin
            dec_op = ESE_OP_PUSH_LIT;
         end
      end
   end

   // Phase and state qualifiers
   wire in_first = (state == ESE_ST_FIRST);
   wire take_word = in_first && (phase == PH_Q1);
   wire q2 = (phase == PH_Q2);
   wire q3 = (phase == PH_Q3);
   wire q4 = (phase == PH_Q4);
   wire first_q4 = in_first && q4;
   wire second_move = (state == ESE_ST_SECOND_MOVE);

   // Fields of the latched words
   wire [1:0] ir_sel = ir[SEL_LSB+1:SEL_LSB];
   wire [ADDR_W-1:0] lit6 = {LIT6_PAD, ir[SEL_LSB-1:LIT6_LSB]};
   wire [ADDR_W-1:0] src_off = {LIT7_PAD, ir[6:0]};
   wire [ADDR_W-1:0] dst_off = {LIT7_PAD, ir2[6:0]};
   wire [ADDR_W-1:0] abs_dst = ir2[ADDR_W-1:0]; // [RQ9] [RQ10]

   // Address forming; 12-bit sums wrap over the data space
   wire [ADDR_W-1:0] src_calc = ptr[2] + src_off; // [RQ9] [RQ14] [RQ17]
   wire [ADDR_W-1:0] dst_calc = ptr[2] + dst_off; // [RQ14] [RQ17]
   wire [ADDR_W-1:0] dst_pick = (op == ESE_OP_MOVE_ABS) ? abs_dst : dst_calc;
   wire src_indirect = (src_addr >= INDIRECT_LO) && (src_addr <= INDIRECT_HI);
   wire dst_indirect = (dst_addr >= INDIRECT_LO) && (dst_addr <= INDIRECT_HI);
   wire dst_blocked = (op == ESE_OP_MOVE_IDX) && dst_indirect; // [RQ13]

   // Actions of the first cycle, at the close of Q4 except the return push in Q2
   wire act_add = first_q4 && (op == ESE_OP_ADD_PTR);
   wire act_addret = first_q4 && (op == ESE_OP_ADD_RET);
   wire act_call = first_q4 && (op == ESE_OP_CALL_W);
   wire act_push = first_q4 && (op == ESE_OP_PUSH_LIT);
   wire is_move = (op == ESE_OP_MOVE_ABS) || (op == ESE_OP_MOVE_IDX);
   wire act_call_push = in_first && q2 && (op == ESE_OP_CALL_W); // [RQ5]
   wire [PC_W-1:0] ret_addr = i_pc + PC_STEP; // [RQ5]
   wire [PC_W-1:0] call_target = {i_counter_latch_upper[4:0], i_counter_latch_high,
                                  i_working_register}; // [RQ6]

   // Memory strobes launched in Q3 so that they stand in Q4
   wire act_move_rd = in_first && q3 && is_move; // [RQ9] [RQ15]
   wire act_push_wr = in_first && q3 && (op == ESE_OP_PUSH_LIT); // [RQ16]
   wire act_move_wr = second_move && q3 && !dst_blocked; // [RQ13] [RQ15]

   // Handshake towards the core: the word is taken by this block
   assign o_claim = take_word && i_instr_valid && dec_any; // [RQ1]
   assign o_owns_cycle = !in_first; // [RQ4] [RQ7] [RQ14]
   assign o_phase = phase;

   always_comb begin
      next_state = state;
      case (state)
         ESE_ST_FIRST: begin
            if (q4 && ((op == ESE_OP_ADD_RET) || (op == ESE_OP_CALL_W))) begin
               next_state = ESE_ST_SECOND_NOP; // [RQ4] [RQ7]
            end else if (q4 && is_move) begin
               next_state = ESE_ST_SECOND_MOVE; // [RQ14] [RQ15]
            end
         end
         ESE_ST_SECOND_NOP: begin
            if (q4) begin
               next_state = ESE_ST_FIRST;
            end
         end
         ESE_ST_SECOND_MOVE: begin
            if (q4) begin
               next_state = ESE_ST_FIRST;
            end
         end
         default: begin
            next_state = ESE_ST_FIRST;
         end
      endcase
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         state <= ESE_ST_FIRST;
      end else begin
         state <= next_state;
      end
   end

   // Latch of the first word and its decoded operation
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         op <= ESE_OP_NONE;
         ir <= 16'h0000;
      end else if (take_word) begin
         op <= i_instr_valid ? dec_op : ESE_OP_NONE;
         ir <= i_instr_word;
      end else if (next_state == ESE_ST_FIRST && q4) begin
         op <= ESE_OP_NONE;
      end
   end

   // Second word of a move arrives in Q1 of the second cycle
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         ir2 <= 16'h0000;
      end else if (second_move && (phase == PH_Q1)) begin
         ir2 <= i_instr_word;
      end
   end

   // Source address in Q2 of the first cycle, destination in Q2 of the second
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         src_addr <= ADDR_RESET;
         dst_addr <= ADDR_RESET;
      end else if (in_first && q2) begin
         src_addr <= src_calc;
      end else if (second_move && q2) begin
         dst_addr <= dst_pick;
      end
   end

   // Source data, forced to zero on an indirect register
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         move_data <= BYTE_RESET;
      end else if (in_first && q4 && is_move) begin
         move_data <= src_indirect ? BYTE_RESET : i_mem_rdata; // [RQ12]
      end
   end

   // Return stack and counter strobes
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         o_stack_push <= 1'b0;
         o_stack_push_data <= PC_RESET;
         o_stack_pop <= 1'b0;
         o_pc_load <= 1'b0;
         o_pc_load_value <= PC_RESET;
      end else begin
         o_stack_push <= act_call_push; // [RQ5]
         o_stack_pop <= act_addret; // [RQ3]
         o_pc_load <= act_addret || act_call; // [RQ3] [RQ6]
         if (act_call_push) begin
            o_stack_push_data <= ret_addr; // [RQ5]
         end
         if (act_addret) begin
            o_pc_load_value <= i_return_stack_top; // [RQ3]
         end else if (act_call) begin
            // Working register is only read, never written back [RQ8]
            o_pc_load_value <= call_target; // [RQ6]
         end
      end
   end

   // Data memory strobes
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         o_mem_rd <= 1'b0;
         o_mem_wr <= 1'b0;
         o_mem_addr <= ADDR_RESET;
         o_mem_wdata <= BYTE_RESET;
      end else begin
         o_mem_rd <= act_move_rd; // [RQ9] [RQ15]
         o_mem_wr <= act_push_wr || act_move_wr; // [RQ16] [RQ15]
         if (act_move_rd) begin
            o_mem_addr <= src_addr; // [RQ9] [RQ14]
         end else if (act_push_wr) begin
            // Old pointer 2, written before its decrement in Q4
            o_mem_addr <= ptr[2]; // [RQ16]
            o_mem_wdata <= ir[7:0]; // [RQ16]
         end else if (act_move_wr) begin
            // Target never a counter or stack top byte [RQ11]
            o_mem_addr <= dst_addr; // [RQ9] [RQ14]
            o_mem_wdata <= move_data; // [RQ9] [RQ14]
         end
      end
   end

   // File select pointers; block updates win over core writes
   for (genvar g = 0; g < PTR_COUNT; g++) begin : g_ptr
      wire sel_hit = (ir_sel == 2'(g));
      wire add_hit = act_add && sel_hit; // [RQ2]
      wire ret_hit = (g == 2) && act_addret; // [RQ3]
      wire push_hit = (g == 2) && act_push; // [RQ16]
      wire core_hit = i_ptr_wr_en && (i_ptr_wr_sel == 2'(g));
      wire [ADDR_W-1:0] sum = ptr[g] + lit6; // [RQ2] [RQ17]
      wire [ADDR_W-1:0] dec = ptr[g] - PTR_DECREMENT; // [RQ16] [RQ17]
      always_ff @(posedge i_core_clk) begin
         if (i_rst) begin
            ptr[g] <= PTR_RESET;
         end else if (add_hit || ret_hit) begin
            ptr[g] <= sum; // [RQ2] [RQ3]
         end else if (push_hit) begin
            ptr[g] <= dec; // [RQ16]
         end else if (core_hit) begin
            ptr[g] <= i_ptr_wr_data;
         end
      end
   end

   assign o_pointer0 = ptr[0];
   assign o_pointer1 = ptr[1];
   assign o_pointer2 = ptr[2];

endmodule // ese_exec

/* File: ese_exec_sva.sv */
/* Port checker for the extended stack instruction executer.
   Assumes it is bound to ese_exec, one clock, sync reset. */
`timescale 1ns/10ps
module ese_exec_sva
   import ese_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_extended_set_enable,
   input wire logic [15:0] i_instr_word,
   input wire logic i_instr_valid,
   input wire logic [PC_W-1:0] i_pc,
   input wire logic [PC_W-1:0] i_return_stack_top,
   input wire logic [7:0] i_working_register,
   input wire logic [7:0] i_counter_latch_high,
   input wire logic [7:0] i_counter_latch_upper,
   input wire logic [1:0] o_phase,
   input wire logic o_claim,
   input wire logic o_owns_cycle,
   input wire logic [ADDR_W-1:0] o_pointer0,
   input wire logic [ADDR_W-1:0] o_pointer2,
   input wire logic o_stack_push,
   input wire logic [PC_W-1:0] o_stack_push_data,
   input wire logic o_stack_pop,
   input wire logic o_pc_load,
   input wire logic [PC_W-1:0] o_pc_load_value,
   input wire logic o_mem_rd,
   input wire logic o_mem_wr,
   input wire logic [ADDR_W-1:0] o_mem_addr,
   input wire logic [7:0] o_mem_wdata
);
   wire push_c = o_claim && i_instr_word[15:8] == OP_PUSH_LIT;
   wire add0_c = o_claim && i_instr_word[15:6] == {OP_ADD_PTR, 2'h0};
   wire ret_c = o_claim && i_instr_word[15:6] == {OP_ADD_PTR, SEL_RETURN_FORM};
   wire call_c = o_claim && i_instr_word == OP_CALL_WORKING_REGISTER;
   wire move_c = o_claim && i_instr_word[15:8] == OP_MOVE;
   wire mvabs_c = move_c && !i_instr_word[MOVE_KIND_BIT];
   wire [4:0] upper5 = i_counter_latch_upper[4:0];
   wire [5:0] k6 = i_instr_word[5:0];
   wire [6:0] zs = i_instr_word[6:0];
   wire [7:0] k8 = i_instr_word[7:0];
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   property p_claim;
      o_claim |-> i_extended_set_enable && i_instr_valid && o_phase == PH_Q1 && !o_owns_cycle;
   endproperty
   a_claim: assert property (p_claim) else $error("claim outside enabled Q1");
   property p_add_ptr;
      add0_c |=> ##3 o_pointer0 == $past(o_pointer0, 4) + {LIT6_PAD, $past(k6, 4)};
   endproperty
   a_add_ptr: assert property (p_add_ptr) else $error("pointer add wrong");
   property p_add_ret;
      ret_c |=> ##3 o_stack_pop && o_pc_load && o_pc_load_value == $past(i_return_stack_top)
         && o_pointer2 == $past(o_pointer2, 4) + {LIT6_PAD, $past(k6, 4)};
   endproperty
   a_add_ret: assert property (p_add_ret) else $error("add and return wrong");
   property p_two_cycle;
      ret_c || call_c |=> ##3 o_owns_cycle [*4] ##1 !o_owns_cycle;
   endproperty
   a_two_cycle: assert property (p_two_cycle) else $error("second cycle wrong");
   property p_call_push;
      call_c |=> ##1 o_stack_push && o_stack_push_data == $past(i_pc) + PC_STEP;
   endproperty
   a_call_push: assert property (p_call_push) else $error("return push wrong");
   property p_call_load;
      call_c |=> ##3 o_pc_load && o_pc_load_value ==
         {$past(upper5), $past(i_counter_latch_high), $past(i_working_register)};
   endproperty
   a_call_load: assert property (p_call_load) else $error("call target wrong");
   property p_move_rd;
      move_c |=> ##2 o_mem_rd && o_mem_addr == o_pointer2 + {LIT7_PAD, $past(zs, 3)};
   endproperty
   a_move_rd: assert property (p_move_rd) else $error("move source wrong");
   property p_move_wr;
      mvabs_c |=> ##6 o_mem_wr && o_mem_addr == $past(i_instr_word[11:0], 3);
   endproperty
   a_move_wr: assert property (p_move_wr) else $error("move write wrong");
   property p_push_wr;
      push_c |=> ##2 o_mem_wr && o_mem_addr == $past(o_pointer2, 3)
         && o_mem_wdata == $past(k8, 3);
   endproperty
   a_push_wr: assert property (p_push_wr) else $error("push write wrong");
   property p_push_dec;
      push_c |=> ##3 o_pointer2 == $past(o_pointer2, 4) - PTR_DECREMENT;
   endproperty
   a_push_dec: assert property (p_push_dec) else $error("push decrement wrong");
   c_push: cover property (push_c);
   c_move: cover property (move_c);
   c_call: cover property (call_c);
endmodule // ese_exec_sva

/* File: ese_mem_model.sv */
/* Data memory of the core as seen by the executer.
   Assumes reads are answered in the clock of the read strobe. */
`timescale 1ns/10ps
module ese_mem_model
   import ese_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_mem_rd,
   input wire logic i_mem_wr,
   input wire logic [ADDR_W-1:0] i_mem_addr,
   input wire logic [7:0] i_mem_wdata,
   output logic [7:0] o_mem_rdata
);
   logic [7:0] mem [0:4095];
   logic [7:0] last = 8'h00;
   // Outside a read the bus toggles each clock, starting from the complement of the last byte read
   assign o_mem_rdata = i_mem_rd ? mem[i_mem_addr] : ~last;
   always @(posedge i_core_clk) begin
      last <= i_mem_rd ? mem[i_mem_addr] : ~last;
      if (i_mem_wr) begin
         mem[i_mem_addr] <= i_mem_wdata;
      end
   end
endmodule // ese_mem_model

/* File: test_extended_stack_instr_exec.sv */
/* Testbench of the extended stack instruction executer.
   Assumes the checker and memory model files are compiled before it. */
`timescale 1ns/10ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
   $display("wrong value at %0t got %h exp %h", $time, g, e); end end
module test_extended_stack_instr_exec;
   import ese_pkg::*;
   logic i_core_clk = 1'b0, i_rst = 1'b1, en = 1'b0, vld = 1'b0, pwe = 1'b0;
   logic [15:0] word = 16'h0000;
   logic [PC_W-1:0] pc = 21'h0000fe, return_stack_top = 21'h012345;
   logic [7:0] working_register = 8'h06, lath = 8'h10, latu = 8'he0, rdata;
   logic [1:0] psel = 2'h0, ph;
   logic [11:0] pdat = 12'h000, p0, p1, p2, addr;
   logic claim, owns, push, pop, ld, rd, wr;
   logic [PC_W-1:0] pushd, ldv;
   logic [7:0] wd;
   int error_cnt = 0, samples_checked = 0;
   ese_exec uut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_extended_set_enable(en),
      .i_instr_word(word), .i_instr_valid(vld), .i_pc(pc), .i_return_stack_top(return_stack_top),
      .i_working_register(working_register), .i_counter_latch_high(lath), .i_counter_latch_upper(latu),
      .i_mem_rdata(rdata), .i_ptr_wr_en(pwe), .i_ptr_wr_sel(psel), .i_ptr_wr_data(pdat),
      .o_phase(ph), .o_claim(claim), .o_owns_cycle(owns), .o_pointer0(p0), .o_pointer1(p1),
      .o_pointer2(p2), .o_stack_push(push), .o_stack_push_data(pushd), .o_stack_pop(pop),
      .o_pc_load(ld), .o_pc_load_value(ldv), .o_mem_rd(rd), .o_mem_wr(wr),
      .o_mem_addr(addr), .o_mem_wdata(wd));
   ese_mem_model mem (.i_core_clk(i_core_clk), .i_mem_rd(rd), .i_mem_wr(wr),
      .i_mem_addr(addr), .i_mem_wdata(wd), .o_mem_rdata(rdata));
   initial begin
      forever #5 i_core_clk = ~i_core_clk;
   end
   task automatic tick(input int n);
      repeat (n) @(negedge i_core_clk);
   endtask
   task automatic q1();
      do @(negedge i_core_clk); while (ph !== PH_Q1);
   endtask
   task automatic issue(input logic [15:0] w);
      q1();
      word = w;
      vld = 1'b1;
   endtask
   task automatic set_ptr(input logic [1:0] s, input logic [11:0] v);
      q1();
      psel = s;
      pdat = v;
      pwe = 1'b1;
      tick(1);
      pwe = 1'b0;
   endtask
   task automatic t_disabled();
      en = 1'b0;
      set_ptr(2'h2, 12'h1ec);
      issue(16'hea08);
      #1 `CHK(claim, 1'b0)
      tick(4);
      `CHK(wr, 1'b0)
      `CHK(p2, 12'h1ec)
      vld = 1'b0;
      en = 1'b1;
   endtask
   task automatic t_add_ptr();
      for (int s = 0; s < 3; s++) begin
         set_ptr(s[1:0], 12'hffe);
         issue({OP_ADD_PTR, s[1:0], 6'h3f});
         #1 `CHK(claim, 1'b1)
         tick(4);
         vld = 1'b0;
         `CHK(s == 0 ? p0 : s == 1 ? p1 : p2, 12'h03d)
      end
   endtask
   task automatic t_add_ret();
      set_ptr(2'h2, 12'h3ff);
      issue(16'he8e3);
      tick(4);
      `CHK(ph, PH_Q1)
      `CHK({pop, ld, owns}, 3'h7)
      `CHK(ldv, return_stack_top)
      `CHK(p2, 12'h422)
      tick(4);
      `CHK(owns, 1'b0)
      `CHK(p2, 12'h422)
      vld = 1'b0;
   endtask
   task automatic t_call();
      issue(OP_CALL_WORKING_REGISTER);
      tick(2);
      `CHK(push, 1'b1)
      `CHK(pushd, 21'h000100)
      tick(2);
      `CHK({ld, owns, wr}, 3'h6)
      `CHK(ldv, 21'h001006)
      vld = 1'b0;
   endtask
   task automatic t_push(input logic [11:0] v);
      set_ptr(2'h2, v);
      issue(16'hea08);
      tick(3);
      `CHK({wr, addr, wd}, {1'b1, v, 8'h08})
      `CHK(p2, v)
      tick(1);
      `CHK({wr, p2}, {1'b0, v - 12'h001})
      word = 16'hea09;
      tick(3);
      `CHK({wr, addr, wd}, {1'b1, v - 12'h001, 8'h09})
      tick(1);
      `CHK(p2, v - 12'h002)
      vld = 1'b0;
   endtask
   task automatic t_move(input logic [15:0] w1, w2, input logic [11:0] ra, wa,
      input logic dw, input logic [7:0] d);
      issue(w1);
      tick(3);
      `CHK({rd, addr}, {1'b1, ra})
      tick(1);
      word = w2;
      tick(3);
      `CHK(wr, dw)
      if (dw) `CHK({addr, wd}, {wa, d})
      vld = 1'b0;
   endtask
   initial begin
      tick(20);
      i_rst = 1'b0;
      t_disabled();
      t_add_ptr();
      t_add_ret();
      t_call();
      t_push(12'h1ec);
      t_push(12'h000);
      // Destinations never name the counter low or stack top bytes
      mem.mem[12'h085] = 8'h33;
      mem.mem[12'hfe0] = 8'haa;
      mem.mem[12'hfd0] = 8'h5a;
      set_ptr(2'h2, 12'h080);
      t_move(16'heb05, 16'hffff, 12'h085, 12'hfff, 1'b1, 8'h33);
      t_move(16'heb85, 16'hf006, 12'h085, 12'h086, 1'b1, 8'h33);
      set_ptr(2'h2, 12'hfd0);
      t_move(16'heb90, 16'hf07f, 12'hfe0, 12'h04f, 1'b1, 8'h00);
      t_move(16'heb80, 16'hf015, 12'hfd0, 12'hfe5, 1'b0, 8'h00);
      end_of_test();
   end
   initial begin
      #50us;
      error_cnt++;
      end_of_test();
   end
   task automatic end_of_test();
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
endmodule // test_extended_stack_instr_exec
bind ese_exec ese_exec_sva chk (.i_core_clk(i_core_clk), .i_rst(i_rst),
   .i_extended_set_enable(i_extended_set_enable), .i_instr_word(i_instr_word),
   .i_instr_valid(i_instr_valid), .i_pc(i_pc), .i_return_stack_top(i_return_stack_top),
   .i_working_register(i_working_register), .i_counter_latch_high(i_counter_latch_high),
   .i_counter_latch_upper(i_counter_latch_upper), .o_phase(o_phase), .o_claim(o_claim),
   .o_owns_cycle(o_owns_cycle), .o_pointer0(o_pointer0), .o_pointer2(o_pointer2),
   .o_stack_push(o_stack_push), .o_stack_push_data(o_stack_push_data),
   .o_stack_pop(o_stack_pop), .o_pc_load(o_pc_load), .o_pc_load_value(o_pc_load_value),
   .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr), .o_mem_addr(o_mem_addr),
   .o_mem_wdata(o_mem_wdata));
